// File: utrc_pkg.sv
/*
  Shared constants for the serial transmit/receive core: register offsets,
  field positions, reset values, oversampling counts and state codes.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package utrc_pkg;
  localparam int ADDR_W = 5;
  localparam int BAUD_W = 12;
  localparam int FRAME_W = 13;

  localparam logic [ADDR_W-1:0] OFF_DATA = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_CSR_A = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_CSR_B = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_CSR_C = 5'h0C;
  localparam logic [ADDR_W-1:0] OFF_BAUD = 5'h10;

  // Status/control A
  localparam int A_RXC = 7;
  localparam int A_TXC = 6;
  localparam int A_UDRE = 5;
  localparam int A_DBL = 1;
  // Control B
  localparam int B_TXCIE = 6;
  localparam int B_UDRIE = 5;
  localparam int B_RXEN = 4;
  localparam int B_TRANSMITTER_ENABLE = 3;
  localparam int B_SZ2 = 2;
  localparam int B_RX9 = 1;
  localparam int B_TX9 = 0;
  localparam logic [7:0] B_WMASK = 8'h7D;
  // Control C
  localparam int C_MASTER = 7;
  localparam int C_SYNC = 6;
  localparam int C_PEN = 5;
  localparam int C_PODD = 4;
  localparam int C_STOP2 = 3;
  localparam int C_SZ1 = 2;
  localparam int C_SZ0 = 1;
  localparam int C_CPOL = 0;

  localparam logic [7:0] RST_A = 8'h00;
  localparam logic [7:0] RST_B = 8'h00;
  localparam logic [7:0] RST_C = 8'h06;
  localparam logic [11:0] RST_BAUD = 12'h000;

  localparam logic [2:0] SZ_NINE = 3'h7;
  localparam logic [3:0] OVS_NORM = 4'hF;
  localparam logic [3:0] OVS_DBL = 4'h7;
  localparam logic [3:0] HALF_NORM = 4'h7;
  localparam logic [3:0] HALF_DBL = 4'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_START = 3'b010,
    RX_DATA = 3'b100
  } utrc_rx_e;
endpackage

// File: utrc_core.sv
/*
  Serial transmit/receive core with an AXI4-Lite register slave.
  Assumes pin inputs are asynchronous to aclk; the surrounding pad logic
  muxes pins using the output enables given here.
*/
`timescale 1ns/1ps

// How it works
// - Transmit enable drives the serial output pin instead of the port.
// - Synchronous mode with transmitter on uses the external clock pin.
// - Writing the data register with the transmitter enabled fills the transmit buffer and starts sending.
// - Buffer moves to shifter when idle or right after the last stop bit.
// - Shifter sends a full frame at the divider rate or external clock.
// - Upper data bits beyond the character size are dropped when framing.
// - Nine-bit mode sends the ninth-bit control bit, latched at data write.
// - Buffer-empty flag is one when empty, zero while data waits.
// - A data register write with the transmitter enabled clears the buffer-empty flag.
// - Buffer-empty request stays high while enabled and the flag is set.
// - Transmit-complete sets when the frame is out and buffer is empty.
// - Transmit-complete clears on interrupt service or a one written.
// - Transmit-complete request rises when enabled and the flag sets.
// - Parity enabled inserts parity after data, before the first stop.
// - Transmitter disable waits until shifter and buffer are empty.
// - Receiver enable makes the serial input pin feed the receiver.
// - Synchronous receive clocks data on the external clock.
// - Reception starts on a valid start bit, then samples each bit.
// - Receiver ignores a second stop bit; frame ends at the first.
// - At the first stop bit the shifter moves into the receive buffer.
// - Unused upper bits of short characters read as zero.
// - Frame is start bit, then data least significant bit first.
// - Parity is the xor of data bits, inverted for odd parity.
// - Lower parity mode bit picks odd or even parity.
// - Receive-complete reads one while unread data sits in the buffer.
module utrc_core
  import utrc_pkg::*;
#(
  parameter int BAUD_BITS = BAUD_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic serial_out_pin,
  output logic serial_out_oe,
  input wire logic serial_in_pin,
  output logic serial_in_owned,
  input wire logic external_serial_clock_in,
  output logic external_serial_clock_out,
  output logic external_serial_clock_oe,
  output logic tx_empty_irq,
  output logic tx_done_irq,
  input wire logic tx_done_irq_ack
);
  function automatic logic [3:0] data_bits(input logic [2:0] sz);
    logic [3:0] n;
    n = 4'h8;
    if (sz == SZ_NINE) begin
      n = 4'h9;
    end else if (sz < 3'h4) begin
      n = 4'h5 + {2'h0, sz[1:0]};
    end
    return n;
  endfunction

  function automatic logic [FRAME_W-1:0] build_frame(input logic [8:0] d, input logic [3:0] nb,
                                                     input logic pen, input logic podd);
    logic [FRAME_W-1:0] f;
    logic p;
    f = '1;
    f[0] = 1'b0;
    p = podd;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < nb) begin
        f[i+1] = d[i];
        p = p ^ d[i];
      end
    end
    if (pen) begin
      f[nb+4'h1] = p;
    end
    return f;
  endfunction

  function automatic logic [7:0] mask_low(input logic [8:0] d, input logic [3:0] nb);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < nb) begin
        m[i] = d[i];
      end
    end
    return m;
  endfunction

  logic [7:0] ctrl_b_q, ctrl_c_q;
  logic dbl_q;
  logic [BAUD_BITS-1:0] baud_q, baud_cnt_q;
  logic tick;
  logic [3:0] ovs_q;

  logic aw_have_q, w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire, wr_ok, rd_ok, ar_fire;
  logic [31:0] rd_word;

  logic [2:0] rxd_sync_q, xck_sync_q;
  logic rxd_lvl_q, xck_lvl_q, xck_q, ck_prev_q;
  logic ck, chg_edge, smp_edge;

  logic tx_busy_q, tx_full_q, txd_q, txc_q, tx_fin, tx_step, dat_wr;
  logic [FRAME_W-1:0] tx_sh_q, frame;
  logic [3:0] tx_left_q, frame_len;
  logic [8:0] tbuf_q;

  utrc_rx_e rx_state_q;
  logic [3:0] rx_cnt_q, rx_ph_q, rx_last;
  logic [10:0] rx_sh_q;
  logic [8:0] rbuf_q;
  logic rxc_q, rx_samp, rx_done, rx_pop;

  logic transmitter_enable, rxen, sync_mode, master, cpol;
  logic [3:0] nb;
  assign transmitter_enable = ctrl_b_q[B_TRANSMITTER_ENABLE];
  assign rxen = ctrl_b_q[B_RXEN];
  assign sync_mode = ctrl_c_q[C_SYNC];
  assign master = ctrl_c_q[C_MASTER];
  assign cpol = ctrl_c_q[C_CPOL];
  assign nb = data_bits({ctrl_b_q[B_SZ2], ctrl_c_q[C_SZ1], ctrl_c_q[C_SZ0]});

  // Register bus: write side
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_ok = aw_addr_q inside {OFF_DATA, OFF_CSR_A, OFF_CSR_B, OFF_CSR_C, OFF_BAUD};
  assign dat_wr = wr_fire && aw_addr_q == OFF_DATA && w_strb_q[0] && transmitter_enable;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      s_axi_awready <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end else if (!aw_have_q && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      s_axi_wready <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end else if (!w_have_q && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers; flag bits of A are not storage, only DBL of A is kept here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_b_q <= RST_B;
      ctrl_c_q <= RST_C;
      dbl_q <= RST_A[A_DBL];
      baud_q <= RST_BAUD;
    end else if (wr_fire && w_strb_q[0]) begin
      unique case (aw_addr_q)
        OFF_CSR_A: dbl_q <= w_data_q[A_DBL];
        OFF_CSR_B: ctrl_b_q <= w_data_q[7:0] & B_WMASK;
        OFF_CSR_C: ctrl_c_q <= w_data_q[7:0];
        OFF_BAUD: baud_q[7:0] <= w_data_q[7:0];
        default: ;
      endcase
      if (aw_addr_q == OFF_BAUD && w_strb_q[1]) begin
        baud_q[BAUD_BITS-1:8] <= w_data_q[BAUD_BITS-1:8];
      end
    end else if (wr_fire && w_strb_q[1] && aw_addr_q == OFF_BAUD) begin
      baud_q[BAUD_BITS-1:8] <= w_data_q[BAUD_BITS-1:8];
    end
  end

  // Register bus: read side; reading data pops the receive buffer
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign rd_ok = s_axi_araddr inside {OFF_DATA, OFF_CSR_A, OFF_CSR_B, OFF_CSR_C, OFF_BAUD};
  assign rx_pop = ar_fire && s_axi_araddr == OFF_DATA;

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      OFF_DATA: rd_word[7:0] = mask_low(rbuf_q, nb);
      OFF_CSR_A: rd_word[7:0] = {rxc_q, txc_q, !tx_full_q, 3'h0, dbl_q, 1'b0};
      OFF_CSR_B: rd_word[7:0] = {ctrl_b_q[7:2], rbuf_q[8], ctrl_b_q[0]};
      OFF_CSR_C: rd_word[7:0] = ctrl_c_q;
      OFF_BAUD: rd_word[BAUD_BITS-1:0] = baud_q;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      s_axi_rvalid <= !s_axi_rready;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Pin synchronisers: a level counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_sync_q <= 3'h7;
      xck_sync_q <= 3'h0;
      rxd_lvl_q <= 1'b1;
      xck_lvl_q <= 1'b0;
    end else begin
      rxd_sync_q <= {rxd_sync_q[1:0], serial_in_pin};
      xck_sync_q <= {xck_sync_q[1:0], external_serial_clock_in};
      if (rxd_sync_q[1] == rxd_sync_q[2]) begin
        rxd_lvl_q <= rxd_sync_q[2];
      end
      if (xck_sync_q[1] == xck_sync_q[2]) begin
        xck_lvl_q <= xck_sync_q[2];
      end
    end
  end

  // Baud divider: one tick every baud_q+1 cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_cnt_q <= RST_BAUD;
      tick <= 1'b0;
      ovs_q <= OVS_NORM;
    end else begin
      tick <= baud_cnt_q == '0;
      baud_cnt_q <= (baud_cnt_q == '0) ? baud_q : baud_cnt_q - 1'b1;
      if (tick) begin
        ovs_q <= (ovs_q == 4'h0) ? (dbl_q ? OVS_DBL : OVS_NORM) : ovs_q - 4'h1;
      end
    end
  end

  // Synchronous clock: master toggles on ticks, slave follows the pin
  assign ck = master ? xck_q : xck_lvl_q;
  assign chg_edge = sync_mode && (cpol ? (ck_prev_q && !ck) : (!ck_prev_q && ck));
  assign smp_edge = sync_mode && (cpol ? (!ck_prev_q && ck) : (ck_prev_q && !ck));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xck_q <= 1'b0;
      ck_prev_q <= 1'b0;
      external_serial_clock_out <= 1'b0;
      external_serial_clock_oe <= 1'b0;
    end else begin
      ck_prev_q <= ck;
      if (sync_mode && master && tick && (serial_out_oe || rxen)) begin
        xck_q <= !xck_q;
      end
      external_serial_clock_out <= xck_q;
      external_serial_clock_oe <= sync_mode && master && (serial_out_oe || rxen);
    end
  end

  // Transmitter
  assign frame = build_frame(tbuf_q, nb, ctrl_c_q[C_PEN], ctrl_c_q[C_PODD]);
  assign frame_len = 4'h2 + nb + {3'h0, ctrl_c_q[C_PEN]} + {3'h0, ctrl_c_q[C_STOP2]};
  assign tx_step = sync_mode ? chg_edge : (tick && ovs_q == 4'h0);
  assign tx_fin = tx_busy_q && tx_step && tx_left_q == 4'h0 && !tx_full_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_busy_q <= 1'b0;
      tx_full_q <= 1'b0;
      tx_sh_q <= '1;
      tx_left_q <= 4'h0;
      txd_q <= 1'b1;
      tbuf_q <= 9'h000;
    end else begin
      if (!tx_busy_q && tx_full_q) begin
        tx_sh_q <= frame;
        tx_left_q <= frame_len;
        tx_busy_q <= 1'b1;
        tx_full_q <= 1'b0;
      end else if (tx_busy_q && tx_step) begin
        if (tx_left_q != 4'h0) begin
          txd_q <= tx_sh_q[0];
          tx_sh_q <= {1'b1, tx_sh_q[FRAME_W-1:1]};
          tx_left_q <= tx_left_q - 4'h1;
        end else if (tx_full_q) begin
          txd_q <= frame[0];
          tx_sh_q <= {1'b1, frame[FRAME_W-1:1]};
          tx_left_q <= frame_len - 4'h1;
          tx_full_q <= 1'b0;
        end else begin
          tx_busy_q <= 1'b0;
          txd_q <= 1'b1;
        end
      end
      if (dat_wr) begin
        tbuf_q <= {ctrl_b_q[B_TX9], w_data_q[7:0]};
        tx_full_q <= 1'b1;
      end
    end
  end

  // Flag set wins over both ways of clearing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txc_q <= 1'b0;
    end else begin
      txc_q <= tx_fin || (txc_q && !tx_done_irq_ack &&
               !(wr_fire && w_strb_q[0] && aw_addr_q == OFF_CSR_A && w_data_q[A_TXC]));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_empty_irq <= 1'b0;
      tx_done_irq <= 1'b0;
      serial_out_oe <= 1'b0;
      serial_out_pin <= 1'b1;
      serial_in_owned <= 1'b0;
    end else begin
      tx_empty_irq <= ctrl_b_q[B_UDRIE] && !tx_full_q;
      tx_done_irq <= ctrl_b_q[B_TXCIE] && txc_q;
      serial_out_oe <= transmitter_enable || tx_busy_q || tx_full_q;
      serial_out_pin <= txd_q;
      serial_in_owned <= rxen;
    end
  end

  // Receiver; disabling it drops any frame in progress
  assign rx_last = nb + {3'h0, ctrl_c_q[C_PEN]};
  assign rx_samp = sync_mode ? smp_edge : (tick && rx_ph_q == 4'h0);
  assign rx_done = rx_state_q == RX_DATA && rx_samp && rx_cnt_q == rx_last;

  always_ff @(posedge aclk) begin
    if (!aresetn || !rxen) begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q <= 4'h0;
      rx_ph_q <= 4'h0;
      rx_sh_q <= 11'h000;
    end else begin
      if (tick && rx_state_q != RX_IDLE) begin
        rx_ph_q <= (rx_ph_q == 4'h0) ? (dbl_q ? OVS_DBL : OVS_NORM) : rx_ph_q - 4'h1;
      end
      unique case (rx_state_q)
        RX_IDLE: begin
          rx_cnt_q <= 4'h0;
          if (sync_mode) begin
            if (smp_edge && !rxd_lvl_q) begin
              rx_state_q <= RX_DATA;
            end
          end else if (!rxd_lvl_q) begin
            rx_state_q <= RX_START;
            rx_ph_q <= dbl_q ? HALF_DBL : HALF_NORM;
          end
        end
        RX_START: begin
          if (rx_samp) begin
            // Mid-bit recheck rejects glitches as start bits
            rx_state_q <= rxd_lvl_q ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_samp) begin
            rx_sh_q[rx_cnt_q] <= rxd_lvl_q;
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_done) begin
              rx_state_q <= RX_IDLE;
            end
          end
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // Single-entry receive buffer
  always_ff @(posedge aclk) begin
    if (!aresetn || !rxen) begin
      rxc_q <= 1'b0;
      rbuf_q <= 9'h000;
    end else if (rx_done) begin
      rbuf_q <= {nb == 4'h9 ? rx_sh_q[8] : 1'b0, rx_sh_q[7:0]};
      rxc_q <= 1'b1;
    end else if (rx_pop) begin
      rxc_q <= 1'b0;
    end
  end
endmodule

// File: utrc_chk.sv
/*
  Assertion checker for utrc_core, bound in from the testbench.
  Sees only top-level ports; everything runs on aclk.
*/
`timescale 1ns/1ps
module utrc_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe,
  input wire logic serial_in_owned,
  input wire logic tx_done_irq,
  input wire logic tx_done_irq_ack
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped before bready");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read data changed before rready");
  // Pin ownership is only gained by a register write and only released on a high line
  property p_oe_rise;
    $rose(serial_out_oe) |-> s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("output enable rose without a write");
  property p_oe_drop;
    $fell(serial_out_oe) |-> serial_out_pin && $past(serial_out_pin);
  endproperty
  a_oe_drop: assert property (p_oe_drop)
    else $error("pin released in mid frame");
  // Short bound so synchronous master bits also hold
  property p_start;
    $fell(serial_out_pin) |-> (serial_out_oe && !serial_out_pin) [*2];
  endproperty
  a_start: assert property (p_start)
    else $error("start bit too short or pin not owned");
  property p_done_stop;
    $rose(tx_done_irq) |-> serial_out_pin && $past(serial_out_pin, 2);
  endproperty
  a_done_stop: assert property (p_done_stop)
    else $error("transmit complete raised before stop bit");
  property p_done_ack;
    tx_done_irq && tx_done_irq_ack |-> ##[1:3] !tx_done_irq;
  endproperty
  a_done_ack: assert property (p_done_ack)
    else $error("transmit complete not cleared by service");
  property p_done_hold;
    tx_done_irq && !tx_done_irq_ack && !$past(tx_done_irq_ack) |=>
      tx_done_irq || s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("transmit complete request dropped by itself");
  property p_owned;
    $changed(serial_in_owned) |-> s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_owned: assert property (p_owned)
    else $error("input pin ownership changed without a write");
endmodule

// File: utrc_peer.sv
/*
  Behavioural remote serial transceiver on the data lines of utrc_core.
  Asynchronous frames only; bit time fixed in aclk cycles.
*/
`timescale 1ns/1ps
module utrc_peer #(
  parameter int BT = 16
) (
  input wire logic aclk,
  input wire logic line_in,
  input wire logic [3:0] nb,
  output logic line_out,
  output logic got,
  output logic [11:0] frame
);
  int i;
  // Caller puts the stop bit(s) at the top of v
  task automatic send(input logic [11:0] v, input int n);
    @(posedge aclk);
    line_out <= 1'b0;
    repeat (BT) @(posedge aclk);
    for (int j = 0; j < n; j++) begin
      line_out <= v[j];
      repeat (BT) @(posedge aclk);
    end
  endtask
  initial begin
    line_out = 1'b1;
    got = 1'b0;
    frame = '0;
    forever begin
      @(negedge line_in);
      repeat (BT / 2) @(posedge aclk);
      if (!line_in) begin
        frame = '0;
        for (i = 0; i <= nb; i++) begin
          repeat (BT) @(posedge aclk);
          frame[i] = line_in;
        end
        got <= 1'b1;
        @(posedge aclk);
        got <= 1'b0;
      end
    end
  end
endmodule

// File: test_usart_tx_rx_core.sv
/*
  Self-checking testbench for utrc_core with a remote serial peer.
  Assumes baud divider 0, so one bit lasts 16 aclk cycles.
*/
`timescale 1ns/1ps
module test_usart_tx_rx_core import utrc_pkg::*;;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, tx_done_irq_ack = 0;
  logic [31:0] s_axi_wdata = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic serial_out_pin, serial_out_oe, serial_in_pin, serial_in_owned;
  logic tx_empty_irq, tx_done_irq, got, ext_ck, ext_ck_oe;
  logic [11:0] frame;
  logic [3:0] nb = 4'h8;
  logic [7:0] lfsr = 8'h06;
  logic [17:0] xm;
  logic [17:0] q_bus[$];
  logic [11:0] q_tx[$];
  logic [7:0] fmt[6] = '{8'h06, 8'h00, 8'h24, 8'h34, 8'h06, 8'h0A};
  int fails = 0;
  int n_compared = 0;
  utrc_core utrc_core_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .serial_out_pin, .serial_out_oe, .serial_in_pin,
    .serial_in_owned, .external_serial_clock_in(1'b0), .external_serial_clock_out(ext_ck),
    .external_serial_clock_oe(ext_ck_oe), .tx_empty_irq, .tx_done_irq, .tx_done_irq_ack);
  utrc_peer utrc_peer_i (.aclk, .line_in(serial_out_pin), .nb, .line_out(serial_in_pin), .got,
    .frame);
  always #25 aclk = ~aclk;
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction
  // Data masked to size, parity over data only, stop on top
  function automatic logic [11:0] frm(input logic [8:0] d, input int n, input logic [7:0] c);
    logic [11:0] f;
    f = 12'(d) & ((12'h1 << n) - 12'h1);
    if (c[C_PEN]) f = f | (12'(^f ^ c[C_PODD]) << n);
    return f | (12'h1 << (n + c[C_PEN]));
  endfunction
  task automatic cmp(input string n, input logic [11:0] e, input logic [11:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Response ready goes up with the request and stays until the answer
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     input logic [17:0] x);
    logic pa, pw, pr;
    q_bus.push_back(x);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    s_axi_bready <= w;
    s_axi_rready <= !w;
    pa = 1'b1;
    pw = w;
    pr = 1'b1;
    while (pr) begin
      @(posedge aclk);
      if (pa && (w ? s_axi_awready : s_axi_arready)) begin
        pa = 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (pw && s_axi_wready) begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (w ? s_axi_bvalid : s_axi_rvalid) begin
        pr = 1'b0;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
      end
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d, {8'h00, RESP_OKAY, 8'h00});
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 8'h00, {m, RESP_OKAY, e});
  endtask
  task automatic wait_tx();
    for (int k = 0; k < 3000 && q_tx.size() != 0; k++) @(posedge aclk);
    if (q_tx.size() != 0) cmp("tx frames", 12'h0, 12'(q_tx.size()));
    // Let the stop bits finish before the caller reconfigures
    repeat (40) @(posedge aclk);
  endtask
  task automatic send_tx(input logic [7:0] d);
    q_tx.push_back(frm({1'b0, d}, 8, RST_C));
    wr(OFF_DATA, d);
  endtask
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(negedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      xm = q_bus.pop_front();
      cmp("bresp", {10'h0, xm[9:8]}, {10'h0, s_axi_bresp});
    end
    if (s_axi_rvalid && s_axi_rready) begin
      xm = q_bus.pop_front();
      cmp("rresp", {10'h0, xm[9:8]}, {10'h0, s_axi_rresp});
      cmp("rdata", {4'h0, xm[7:0] & xm[17:10]}, {4'h0, s_axi_rdata[7:0] & xm[17:10]});
    end
    if (got) cmp("frame", q_tx.pop_front(), frame);
  end
  initial begin
    repeat (40000) @(posedge aclk);
    fails++;
    $display("mismatch watchdog expected finish seen timeout");
    test_done;
  end
  initial begin
    int n;
    logic [7:0] c, b, d, v;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_CSR_A, 8'hC2, RST_A);
    rd(OFF_CSR_B, 8'hFF, RST_B);
    rd(OFF_CSR_C, 8'hFF, RST_C);
    bus(1'b1, 5'h14, 8'h00, {8'h00, RESP_SLVERR, 8'h00});
    bus(1'b0, 5'h14, 8'h00, {8'h00, RESP_SLVERR, 8'h00});
    wr(OFF_BAUD, 8'h00);
    rd(OFF_BAUD, 8'hFF, RST_BAUD[7:0]);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      c = fmt[i];
      d = rnd();
      b = (i == 4) ? 8'h1C : 8'h18;
      b[B_TX9] = d[0];
      n = b[B_SZ2] ? 9 : 5 + int'(c[2:1]);
      nb <= 4'(n + int'(c[C_PEN]));
      wr(OFF_CSR_C, c);
      wr(OFF_CSR_B, b);
      q_tx.push_back(frm({b[B_TX9], d}, n, c));
      wr(OFF_DATA, d);
      cmp("owned", 12'h1, {11'h0, serial_in_owned});
      v = rnd();
      utrc_peer_i.send(frm({v[0], v}, n, c), n + int'(c[C_PEN]) + 1);
      rd(OFF_CSR_A, 8'h80, 8'h80);
      rd(OFF_CSR_B, b[B_SZ2] ? 8'h02 : 8'h00, {6'h0, v[0], 1'b0});
      rd(OFF_DATA, 8'hFF, (n >= 8) ? v : v & 8'((1 << n) - 1));
      rd(OFF_CSR_A, 8'h80, 8'h00);
      wait_tx;
    end
    $display("test formats done");
    nb <= 4'h8;
    wr(OFF_CSR_C, RST_C);
    wr(OFF_CSR_B, 8'h78);
    wr(OFF_CSR_A, 8'h40);
    rd(OFF_CSR_A, 8'h40, 8'h00);
    send_tx(rnd());
    send_tx(rnd());
    rd(OFF_CSR_A, 8'h60, 8'h00);
    cmp("empty irq", 12'h0, {11'h0, tx_empty_irq});
    wait_tx;
    for (int k = 0; k < 400 && tx_done_irq !== 1'b1; k++) @(posedge aclk);
    cmp("done irq", 12'h1, {11'h0, tx_done_irq});
    cmp("empty irq", 12'h1, {11'h0, tx_empty_irq});
    cmp("idle line", 12'h1, {11'h0, serial_out_pin});
    rd(OFF_CSR_A, 8'h60, 8'h60);
    tx_done_irq_ack <= 1'b1;
    @(posedge aclk);
    tx_done_irq_ack <= 1'b0;
    repeat (3) @(posedge aclk);
    cmp("done irq", 12'h0, {11'h0, tx_done_irq});
    rd(OFF_CSR_A, 8'h40, 8'h00);
    wr(OFF_CSR_B, 8'h18);
    repeat (3) @(posedge aclk);
    cmp("empty irq", 12'h0, {11'h0, tx_empty_irq});
    wr(OFF_CSR_C, 8'hC6);
    repeat (2) @(posedge aclk);
    cmp("clock oe", 12'h1, {11'h0, ext_ck_oe});
    v[0] = ext_ck;
    @(posedge aclk);
    cmp("clock toggle", {11'h0, !v[0]}, {11'h0, ext_ck});
    wr(OFF_CSR_C, RST_C);
    $display("test flags done");
    send_tx(rnd());
    send_tx(rnd());
    wr(OFF_CSR_B, 8'h10);
    cmp("tx oe", 12'h1, {11'h0, serial_out_oe});
    wr(OFF_DATA, rnd());
    wait_tx;
    repeat (40) @(posedge aclk);
    cmp("tx oe", 12'h0, {11'h0, serial_out_oe});
    wr(OFF_CSR_B, 8'h00);
    repeat (300) @(posedge aclk);
    cmp("owned", 12'h0, {11'h0, serial_in_owned});
    cmp("stray frames", 12'h0, 12'(q_tx.size()));
    $display("test disable done");
    test_done;
  end
endmodule
bind utrc_core utrc_chk utrc_chk_i (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .serial_out_pin, .serial_out_oe, .serial_in_owned,
  .tx_done_irq, .tx_done_irq_ack);
